// ==== core/ied_regs.svh ====
`ifndef IED_REGS_SVH
`define IED_REGS_SVH

// ****************************************
// vector numbers and masks
// ****************************************
`define IED_NUM_EXC 20
`define IED_VEC_DF 8'h08
`define IED_VEC_NMI 8'h02
`define IED_VEC_USER 8'h20
// sources that may arrive on exc_req: 0,1,3-7,10-14,16-19
`define IED_EXC_LEGAL 20'hf7cfb
// vectors that push an error code: 8,10-14,17
`define IED_ERR_MASK 20'h27d00
`define IED_IF_BIT 9
`define IED_DEPTH_W 4

`endif

// ==== core/ied_pkg.sv ====
package ied_pkg;

    typedef enum logic [1:0] {
        IED_GATE_INTR = 2'h0,
        IED_GATE_TRAP = 2'h1,
        IED_GATE_TASK = 2'h2
    } ied_gate_e;

    typedef struct packed {
        logic present;
        ied_gate_e kind;
        logic [1:0] dpl;
        logic [15:0] sel;
        logic [31:0] offset;
    } ied_gate_s;

    typedef struct packed {
        logic [31:0] flags;
        logic [15:0] cs;
        logic [31:0] ip;
    } ied_ctx_s;

    typedef enum logic [3:0] {
        IED_ST_IDLE = 4'h0,
        IED_ST_FETCH = 4'h1,
        IED_ST_PUSH_FL = 4'h2,
        IED_ST_PUSH_CS = 4'h3,
        IED_ST_PUSH_IP = 4'h4,
        IED_ST_PUSH_ERR = 4'h5,
        IED_ST_ENTER = 4'h6,
        IED_ST_SMM = 4'h7,
        IED_ST_RET = 4'h8,
        IED_ST_SHUT = 4'h9
    } ied_state_e;

endpackage

// ==== core/ied_first_set.sv ====
`timescale 1ns/1ps
`default_nettype none

// lowest set bit wins
module ied_first_set #(
    parameter int W = 20,
    parameter int IW = $clog2(W)
) (
    input wire logic [W-1:0] req,
    output logic any,
    output logic [IW-1:0] idx
);

    always_comb
    begin
        any = |req;
        idx = '0;
        for (int i = W - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                idx = IW'(i);
            end
        end
    end

endmodule // ied_first_set

`default_nettype wire

// ==== core/ied_dispatch.sv ====
// How it works
// - pin interrupts are asynchronous; exceptions are synchronous
// - any accepted event halts the core; all but smi enter their table handler
// - handler return restores the saved flags, code segment and pointer
// - eight-bit vectors index the descriptor table, 256 entries in all
// - predefined vectors 0-8,10-14,16-19; external vectors 32-255 only
// - system management interrupt bypasses the descriptor table
// - entry is either a handler procedure call or a task switch
// - procedure calls read the entry as interrupt gate or trap gate
// - gate selector and offset become the new code segment and pointer
// - interrupt gate entry clears the interrupt enable flag
// - trap gate entry keeps the interrupt enable flag
// - vector 0 for divide error
// - vector 1 for debug event, vector 2 for non-maskable pin
// - vectors 3, 4, 5 for breakpoint, overflow and range traps
// - vector 6 for invalid opcode
// - vector 7 for math unit unavailable
// - a fault during delivery becomes double fault; another one shuts down
// - vector 9 is reserved; only a software interrupt can raise it
// - vectors 10 and 11 for task segment and absent segment faults
// - vectors 15 and 22-31 reserved; vector 13 for protection faults
// - push flags, code segment, pointer, then any error code
`timescale 1ns/1ps
`default_nettype none
`include "ied_regs.svh"

module ied_dispatch import ied_pkg::*; #(
    parameter int NEXC = `IED_NUM_EXC,
    parameter int DW = `IED_DEPTH_W
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic insn_bound,
    input wire logic [NEXC-1:0] exc_req,
    input wire logic [31:0] exc_err,
    input wire logic sw_int_req,
    input wire logic [7:0] sw_int_vec,
    input wire logic intr_pin,
    input wire logic [7:0] intr_vec_pin,
    input wire logic nmi_pin,
    input wire logic smi_pin,
    input wire ied_ctx_s cur_ctx,
    input wire logic desc_ack,
    input wire ied_gate_s desc_gate,
    input wire logic dlv_fault,
    input wire logic push_ready,
    input wire logic iret_req,
    input wire ied_ctx_s iret_ctx,
    output logic core_halt_ff,
    output logic desc_req_ff,
    output logic [7:0] desc_vec_ff,
    output logic push_valid_ff,
    output logic [31:0] push_data_ff,
    output logic enter_ff,
    output logic task_sw_ff,
    output ied_ctx_s new_ctx_ff,
    output logic intr_ack_ff,
    output logic smm_enter_ff,
    output logic resume_ff,
    output logic shutdown_ff,
    output logic [DW-1:0] depth_ff
);

    localparam int IW = $clog2(NEXC);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [10:0] pin_s1_ff;
    logic [10:0] pin_s2_ff;
    logic nmi_d_ff;
    logic smi_d_ff;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_s1_ff <= 11'h000;
            pin_s2_ff <= 11'h000;
            nmi_d_ff <= 1'b0;
            smi_d_ff <= 1'b0;
        end
        else
        begin
            pin_s1_ff <= {intr_pin, nmi_pin, smi_pin, intr_vec_pin};
            pin_s2_ff <= pin_s1_ff;
            nmi_d_ff <= pin_s2_ff[9];
            smi_d_ff <= pin_s2_ff[8];
        end
    end

    logic intr_s;
    logic [7:0] intr_vec_s;
    assign intr_s = pin_s2_ff[10];
    assign intr_vec_s = pin_s2_ff[7:0];

    // ****************************************
    // pending events and priority
    // ****************************************
    ied_state_e state_ff;
    ied_state_e nxt_state;
    logic nmi_pend_ff;
    logic smi_pend_ff;
    logic nmi_block_ff;
    logic exc_any;
    logic [IW-1:0] exc_idx;
    logic start;
    logic pick_smi;
    logic pick_nmi;
    logic pick_exc;
    logic pick_sw;
    logic pick_intr;
    logic intr_ok;

    ied_first_set #(.W(NEXC)) u_exc_pick (
        .req(exc_req & NEXC'(`IED_EXC_LEGAL)),
        .any(exc_any),
        .idx(exc_idx)
    );

    // a vector below 32 from the controller would alias an exception
    assign intr_ok = intr_s && cur_ctx.flags[`IED_IF_BIT]
        && (intr_vec_s >= `IED_VEC_USER);
    assign start = (state_ff == IED_ST_IDLE) && insn_bound;
    assign pick_smi = start && smi_pend_ff;
    assign pick_nmi = start && !smi_pend_ff && nmi_pend_ff
        && !nmi_block_ff;
    assign pick_exc = start && !smi_pend_ff
        && !(nmi_pend_ff && !nmi_block_ff) && exc_any;
    assign pick_sw = start && !smi_pend_ff
        && !(nmi_pend_ff && !nmi_block_ff) && !exc_any && sw_int_req;
    assign pick_intr = start && !smi_pend_ff
        && !(nmi_pend_ff && !nmi_block_ff) && !exc_any && !sw_int_req
        && intr_ok;

    // set wins over the clear so an edge at delivery is not lost
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            nmi_pend_ff <= 1'b0;
            smi_pend_ff <= 1'b0;
        end
        else
        begin
            nmi_pend_ff <= (pin_s2_ff[9] && !nmi_d_ff)
                || (nmi_pend_ff && !pick_nmi);
            smi_pend_ff <= (pin_s2_ff[8] && !smi_d_ff)
                || (smi_pend_ff && !pick_smi);
        end
    end

    // ****************************************
    // delivery state machine
    // ****************************************
    logic df_ff;
    logic has_err_ff;
    logic src_sw_ff;
    logic [7:0] vec_ff;
    logic [31:0] err_ff;
    ied_ctx_s ctx_ff;
    ied_ctx_s ret_ctx_ff;
    ied_gate_s gate_ff;
    logic push_go;
    logic fault_now;

    assign push_go = push_valid_ff && push_ready;
    assign fault_now = dlv_fault || ((state_ff == IED_ST_FETCH)
        && desc_ack && !desc_gate.present);

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            IED_ST_IDLE:
            begin
                if (pick_smi)
                    nxt_state = IED_ST_SMM;
                else if (pick_nmi || pick_exc || pick_sw || pick_intr)
                    nxt_state = IED_ST_FETCH;
                else if (iret_req && (depth_ff != '0))
                    nxt_state = IED_ST_RET;
            end
            IED_ST_FETCH:
            begin
                if (fault_now)
                    nxt_state = df_ff ? IED_ST_SHUT : IED_ST_FETCH;
                else if (desc_ack && desc_gate.kind == IED_GATE_TASK)
                    nxt_state = IED_ST_ENTER;
                else if (desc_ack)
                    nxt_state = IED_ST_PUSH_FL;
            end
            IED_ST_PUSH_FL, IED_ST_PUSH_CS, IED_ST_PUSH_IP,
            IED_ST_PUSH_ERR:
            begin
                if (dlv_fault)
                    nxt_state = df_ff ? IED_ST_SHUT : IED_ST_FETCH;
                else if (push_go)
                begin
                    case (state_ff)
                        IED_ST_PUSH_FL: nxt_state = IED_ST_PUSH_CS;
                        IED_ST_PUSH_CS: nxt_state = IED_ST_PUSH_IP;
                        IED_ST_PUSH_IP:
                            nxt_state = has_err_ff ? IED_ST_PUSH_ERR
                                : IED_ST_ENTER;
                        default: nxt_state = IED_ST_ENTER;
                    endcase
                end
            end
            IED_ST_ENTER, IED_ST_SMM, IED_ST_RET:
                nxt_state = IED_ST_IDLE;
            IED_ST_SHUT:
                nxt_state = IED_ST_SHUT;
            default:
                nxt_state = IED_ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            state_ff <= IED_ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // ****************************************
    // event context
    // ****************************************
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            vec_ff <= 8'h00;
            err_ff <= 32'h0000_0000;
            has_err_ff <= 1'b0;
            df_ff <= 1'b0;
            src_sw_ff <= 1'b0;
            ctx_ff <= '0;
        end
        else if (state_ff == IED_ST_IDLE && nxt_state == IED_ST_FETCH)
        begin
            ctx_ff <= cur_ctx;
            df_ff <= 1'b0;
            src_sw_ff <= pick_sw;
            err_ff <= exc_err;
            has_err_ff <= pick_exc
                && (((`IED_ERR_MASK >> exc_idx) & 20'h00001) != 20'h00000);
            // exception index equals its vector
            if (pick_nmi)
                vec_ff <= `IED_VEC_NMI;
            else if (pick_exc)
                vec_ff <= 8'(exc_idx);
            else if (pick_sw)
                vec_ff <= sw_int_vec;
            else
                vec_ff <= intr_vec_s;
        end
        else if (fault_now && !df_ff && state_ff != IED_ST_IDLE)
        begin
            vec_ff <= `IED_VEC_DF;
            err_ff <= 32'h0000_0000;
            has_err_ff <= 1'b1;
            df_ff <= 1'b1;
            src_sw_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            gate_ff <= '0;
        else if (state_ff == IED_ST_FETCH && desc_ack)
            gate_ff <= desc_gate;
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            ret_ctx_ff <= '0;
        else if (nxt_state == IED_ST_RET)
            ret_ctx_ff <= iret_ctx;
    end

    // ****************************************
    // table and stack ports
    // ****************************************
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            desc_req_ff <= 1'b0;
            desc_vec_ff <= 8'h00;
        end
        else
        begin
            desc_req_ff <= (nxt_state == IED_ST_FETCH);
            desc_vec_ff <= (fault_now && !df_ff) ? `IED_VEC_DF
                : (state_ff == IED_ST_IDLE) ? nxt_vec() : vec_ff;
        end
    end

    // vector being picked this cycle, for the table request
    function automatic logic [7:0] nxt_vec();
        logic [7:0] v;
        v = intr_vec_s;
        if (pick_nmi)
            v = `IED_VEC_NMI;
        else if (pick_exc)
            v = 8'(exc_idx);
        else if (pick_sw)
            v = sw_int_vec;
        return v;
    endfunction

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            push_valid_ff <= 1'b0;
            push_data_ff <= 32'h0000_0000;
        end
        else
        begin
            push_valid_ff <= 1'b0;
            push_data_ff <= 32'h0000_0000;
            case (nxt_state)
                IED_ST_PUSH_FL:
                begin
                    push_valid_ff <= 1'b1;
                    push_data_ff <= ctx_ff.flags;
                end
                IED_ST_PUSH_CS:
                begin
                    push_valid_ff <= 1'b1;
                    push_data_ff <= {16'h0000, ctx_ff.cs};
                end
                IED_ST_PUSH_IP:
                begin
                    push_valid_ff <= 1'b1;
                    push_data_ff <= ctx_ff.ip;
                end
                IED_ST_PUSH_ERR:
                begin
                    push_valid_ff <= 1'b1;
                    push_data_ff <= err_ff;
                end
                default:
                begin
                    push_valid_ff <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // handler entry, return and core control
    // ****************************************
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            enter_ff <= 1'b0;
            task_sw_ff <= 1'b0;
            resume_ff <= 1'b0;
            new_ctx_ff <= '0;
        end
        else
        begin
            enter_ff <= 1'b0;
            task_sw_ff <= 1'b0;
            resume_ff <= 1'b0;
            if (state_ff == IED_ST_ENTER)
            begin
                task_sw_ff <= (gate_ff.kind == IED_GATE_TASK);
                enter_ff <= (gate_ff.kind != IED_GATE_TASK);
                new_ctx_ff.cs <= gate_ff.sel;
                new_ctx_ff.ip <= gate_ff.offset;
                new_ctx_ff.flags <= ctx_ff.flags;
                if (gate_ff.kind == IED_GATE_INTR)
                    new_ctx_ff.flags[`IED_IF_BIT] <= 1'b0;
            end
            else if (state_ff == IED_ST_RET)
            begin
                resume_ff <= 1'b1;
                new_ctx_ff <= ret_ctx_ff;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            core_halt_ff <= 1'b0;
            intr_ack_ff <= 1'b0;
            smm_enter_ff <= 1'b0;
            shutdown_ff <= 1'b0;
        end
        else
        begin
            core_halt_ff <= (nxt_state != IED_ST_IDLE);
            intr_ack_ff <= pick_intr;
            smm_enter_ff <= (state_ff == IED_ST_SMM);
            shutdown_ff <= (nxt_state == IED_ST_SHUT);
        end
    end

    // nesting depth saturates; nmi stays blocked until the next return
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            depth_ff <= '0;
            nmi_block_ff <= 1'b0;
        end
        else
        begin
            if (state_ff == IED_ST_ENTER && depth_ff != '1)
                depth_ff <= depth_ff + 1'b1;
            else if (state_ff == IED_ST_RET)
                depth_ff <= depth_ff - 1'b1;
            if (pick_nmi)
                nmi_block_ff <= 1'b1;
            else if (state_ff == IED_ST_RET)
                nmi_block_ff <= 1'b0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    halt_on_event_a: assert property (
        (pick_nmi || pick_exc || pick_intr) |=> core_halt_ff && desc_req_ff)
        else $error("event did not halt core and fetch gate");
    divide_vector_a: assert property (
        (pick_exc && exc_req[0]) |=> desc_vec_ff == 8'h00)
        else $error("divide error not on vector 0");
    reserved_vector_a: assert property (
        (desc_req_ff && !src_sw_ff) |-> !(desc_vec_ff inside
        {8'h09, 8'h0f, [8'h16:8'h1f]}))
        else $error("reserved vector requested");
    if_clear_a: assert property (
        (state_ff == IED_ST_ENTER && gate_ff.kind == IED_GATE_INTR)
        |=> enter_ff && !new_ctx_ff.flags[`IED_IF_BIT])
        else $error("interrupt gate left enable flag set");
    if_keep_a: assert property (
        (enter_ff && gate_ff.kind == IED_GATE_TRAP) |->
        new_ctx_ff.flags == ctx_ff.flags)
        else $error("trap gate changed flags");
    push_order_a: assert property (
        (state_ff == IED_ST_PUSH_FL && push_go && !dlv_fault) |=>
        push_valid_ff && push_data_ff == {16'h0000, ctx_ff.cs})
        else $error("code segment not pushed after flags");
    double_fault_a: assert property (
        (state_ff == IED_ST_FETCH && fault_now && !df_ff) |=>
        desc_req_ff && desc_vec_ff == `IED_VEC_DF ##1 !shutdown_ff)
        else $error("delivery fault did not become double fault");
    shutdown_a: assert property (
        (df_ff && fault_now && state_ff inside {IED_ST_FETCH,
        IED_ST_PUSH_FL, IED_ST_PUSH_CS, IED_ST_PUSH_IP, IED_ST_PUSH_ERR})
        |=> shutdown_ff [*3])
        else $error("fault in double fault did not shut down");
    smi_path_a: assert property (
        pick_smi |=> !desc_req_ff ##1 smm_enter_ff)
        else $error("smi used the descriptor table");
    return_a: assert property (
        (state_ff == IED_ST_IDLE && iret_req && depth_ff != '0
        && !(pick_smi || pick_nmi || pick_exc || pick_sw || pick_intr))
        ##1 1'b1 |=> resume_ff && new_ctx_ff == $past(ret_ctx_ff))
        else $error("return did not restore context");
    boundary_a: assert property (
        (state_ff == IED_ST_IDLE && !insn_bound) |=>
        state_ff inside {IED_ST_IDLE, IED_ST_RET})
        else $error("event taken between instructions");

    smi_c: cover property (smm_enter_ff);
    task_c: cover property (task_sw_ff);
    err_push_c: cover property (state_ff == IED_ST_PUSH_ERR && push_go);
    df_c: cover property (df_ff && enter_ff);

endmodule // ied_dispatch

`default_nettype wire

// ==== bench/ied_table_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ********
// descriptor table and stack stand-in
// ********
module ied_table_model import ied_pkg::*; (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic slow,
    input wire logic desc_req,
    input wire logic [7:0] desc_vec,
    output logic desc_ack,
    output ied_gate_s desc_gate,
    output logic push_ready
);
    logic [2:0] cnt_ff;
    ied_gate_s gate;

    // even vectors hold interrupt gates, odd ones trap gates, 0x81 a task
    always_comb
    begin
        gate.present = desc_vec != 8'h0b;
        gate.kind = (desc_vec == 8'h81) ? IED_GATE_TASK
            : desc_vec[0] ? IED_GATE_TRAP : IED_GATE_INTR;
        gate.dpl = 2'h0;
        gate.sel = {8'h10, desc_vec};
        gate.offset = {24'h00a000, desc_vec};
    end

    // between answers the lines carry junk, never the last gate
    assign desc_gate = desc_ack ? gate : ied_gate_s'(~gate);

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            desc_ack <= 1'b0;
            cnt_ff <= 3'h0;
        end
        else if (desc_ack)
        begin
            desc_ack <= 1'b0;
            cnt_ff <= 3'h0;
        end
        else if (desc_req)
        begin
            desc_ack <= cnt_ff == (slow ? 3'h4 : 3'h1);
            cnt_ff <= cnt_ff + 3'h1;
        end
        else
            cnt_ff <= 3'h0;
    end

    // slow stack takes a word every other cycle
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            push_ready <= 1'b0;
        else
            push_ready <= slow ? ~push_ready : 1'b1;
    end
endmodule // ied_table_model

`default_nettype wire

// ==== bench/test_interrupt_exception_dispatch.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ied_regs.svh"

// ********
// dispatch bench
// ********
module test_interrupt_exception_dispatch
    import ied_pkg::*;
;
    logic core_clk = 1'b0;
    logic rstn, insn_bound, sw_int_req, intr_pin, nmi_pin, smi_pin;
    logic iret_req, slow, halt, dreq, dack, pvld, prdy, ent, tsw;
    logic iack, smm, res, dlv_fault, sdn;
    logic [19:0] exc_req;
    logic [31:0] exc_err, pdata;
    logic [31:0] seed = 32'h4b;
    logic [7:0] sw_int_vec, intr_vec_pin, dvec;
    logic [3:0] depth;
    ied_ctx_s cur_ctx, iret_ctx, nctx, ctx;
    ied_gate_s gate;
    logic [81:0] exp_q[$];
    int bad_count = 0;
    int num_checks = 0;

    ied_dispatch uut (
        .core_clk, .rstn, .insn_bound, .exc_req, .exc_err, .sw_int_req,
        .sw_int_vec, .intr_pin, .intr_vec_pin, .nmi_pin, .smi_pin, .cur_ctx,
        .desc_ack(dack), .desc_gate(gate), .dlv_fault,
        .push_ready(prdy), .iret_req, .iret_ctx, .core_halt_ff(halt),
        .desc_req_ff(dreq), .desc_vec_ff(dvec), .push_valid_ff(pvld),
        .push_data_ff(pdata), .enter_ff(ent), .task_sw_ff(tsw),
        .new_ctx_ff(nctx), .intr_ack_ff(iack), .smm_enter_ff(smm),
        .resume_ff(res), .shutdown_ff(sdn), .depth_ff(depth)
    );

    ied_table_model tbl (
        .core_clk, .rstn, .slow, .desc_req(dreq), .desc_vec(dvec),
        .desc_ack(dack), .desc_gate(gate), .push_ready(prdy)
    );

    always #10 core_clk = ~core_clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic ied_ctx_s mkctx();
        logic [95:0] t;
        t = {rnd(), rnd(), rnd()};
        return t[79:0];
    endfunction

    task automatic chk(input string what, input logic [81:0] seen,
                       input logic [81:0] want);
        num_checks++;
        if (seen !== want)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // anything the design shows with no note waiting is a stray event
    task automatic take(input logic [81:0] s);
        if (exp_q.size() == 0)
            chk("stray event", s, ~s);
        else
            chk("event", s, exp_q.pop_front());
    endtask

    always @(posedge core_clk)
    begin
        if (rstn)
        begin
            if (iack)
                take({2'h3, 80'h1});
            if (smm)
                take({2'h3, 80'h2});
            if (dreq && dack)
                take({2'h0, 72'h0, dvec});
            if (pvld && prdy)
                take({2'h1, 48'h0, pdata});
            if (ent || tsw || res)
                take({2'h2, nctx});
        end
    end

    task automatic expect_entry(input logic [7:0] v, input logic [31:0] e);
        logic [7:0] g;
        ied_ctx_s c;
        g = (v == 8'h0b) ? 8'h08 : v;
        exp_q.push_back({2'h0, 72'h0, v});
        if (g != v)
            exp_q.push_back({2'h0, 72'h0, g});
        if (g != 8'h81)
        begin
            exp_q.push_back({2'h1, 48'h0, ctx.flags});
            exp_q.push_back({2'h1, 64'h0, ctx.cs});
            exp_q.push_back({2'h1, 48'h0, ctx.ip});
        end
        if (g < 8'h14 && ((`IED_ERR_MASK >> g) & 20'h1))
            exp_q.push_back({2'h1, 48'h0, (g != v) ? 32'h0 : e});
        c.flags = ctx.flags;
        if (!g[0])
            c.flags[9] = 1'b0;
        c.cs = {8'h10, g};
        c.ip = {24'h00a000, g};
        exp_q.push_back({2'h2, c});
    endtask

    task automatic wait_halt(input logic lvl);
        repeat (200)
        begin
            @(posedge core_clk);
            if (halt === lvl)
                return;
        end
        chk("halt wait", {81'h0, ~lvl}, {81'h0, lvl});
    endtask

    // src: 0 exception mask, 1 software, 2 pin, 3 non-maskable, 4 smi
    task automatic fire(input logic [2:0] src, input logic [7:0] v,
                        input logic [19:0] m);
        logic [31:0] e;
        ctx = mkctx();
        ctx.flags[9] = 1'b1;
        e = rnd();
        if (src == 3'h2)
            exp_q.push_back({2'h3, 80'h1});
        if (src == 3'h4)
            exp_q.push_back({2'h3, 80'h2});
        else
            expect_entry(v, e);
        @(posedge core_clk);
        cur_ctx <= ctx;
        exc_err <= e;
        case (src)
            3'h0: exc_req <= m;
            3'h1: sw_int_req <= 1'b1;
            3'h2: intr_pin <= 1'b1;
            3'h3: nmi_pin <= 1'b1;
            default: smi_pin <= 1'b1;
        endcase
        sw_int_vec <= v;
        intr_vec_pin <= v;
        insn_bound <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("early start", {81'h0, halt}, 82'h0);
        insn_bound <= 1'b1;
        wait_halt(1'b1);
        exc_req <= '0;
        {sw_int_req, intr_pin, nmi_pin, smi_pin} <= 4'h0;
        wait_halt(1'b0);
        repeat (3) @(posedge core_clk);
    endtask

    // single-cycle return request, resume follows two edges later
    task automatic back;
        ied_ctx_s r;
        r = mkctx();
        chk("depth", {78'h0, depth}, 82'h1);
        exp_q.push_back({2'h2, r});
        @(posedge core_clk);
        iret_ctx <= r;
        iret_req <= 1'b1;
        @(posedge core_clk);
        iret_req <= 1'b0;
        repeat (5) @(posedge core_clk);
        chk("depth", {78'h0, depth}, 82'h0);
    endtask

    // requests that must be ignored: nothing may start
    task automatic quiet(input logic [19:0] m, input logic [7:0] v,
                         input logic ie);
        @(posedge core_clk);
        ctx.flags[9] = ie;
        cur_ctx <= ctx;
        exc_req <= m;
        intr_pin <= 1'b1;
        intr_vec_pin <= v;
        repeat (12) @(posedge core_clk);
        exc_req <= '0;
        intr_pin <= 1'b0;
        repeat (4) @(posedge core_clk);
        chk("halt", {81'h0, halt}, 82'h0);
    endtask

    initial
    begin
        {rstn, insn_bound, sw_int_req, intr_pin} = 4'h0;
        {nmi_pin, smi_pin, iret_req, slow, dlv_fault} = 5'h00;
        exc_req = '0;
        exc_err = '0;
        sw_int_vec = '0;
        intr_vec_pin = '0;
        cur_ctx = '0;
        iret_ctx = '0;
        ctx = '0;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        insn_bound <= 1'b1;
        for (int v = 0; v < 20; v++)
        begin
            if ((`IED_EXC_LEGAL >> v) & 20'h1)
            begin
                slow <= ~slow;
                fire(3'h0, 8'(v), 20'h1 << v);
                back();
            end
        end
        fire(3'h0, 8'h06, 20'h01040);
        back();
        fire(3'h1, 8'h81, '0);
        back();
        fire(3'h2, 8'h40, '0);
        back();
        fire(3'h3, 8'h02, '0);
        back();
        quiet(20'h08304, 8'h10, 1'b1);
        quiet('0, 8'h40, 1'b0);
        fire(3'h4, 8'h00, '0);
        // a fault while fetching the double-fault gate shuts down
        exp_q.push_back({2'h0, 72'h0, 8'h0b});
        exc_req <= 20'h00800;
        while (!(dreq && dvec == `IED_VEC_DF))
            @(posedge core_clk);
        dlv_fault <= 1'b1;
        exc_req <= '0;
        @(posedge core_clk);
        dlv_fault <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("shutdown", {80'h0, sdn, halt}, 82'h3);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("reset", {80'h0, sdn, halt}, 82'h0);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk("left over", 82'(exp_q.size()), 82'h0);
        results();
    end

    initial
    begin
        #200000;
        bad_count++;
        results();
    end
endmodule // test_interrupt_exception_dispatch

`default_nettype wire
